// file: secp_dev_model.sv
// Behavioural model of the serial EEPROM that the host drives
`timescale 1ns/1ps
module secp_dev_model #(
    parameter logic [15:0] ERASE_VAL = 16'hFFFF,
    parameter real SEL_GAP_NS = 40.0,
    parameter real PROG_MIN_NS = 10000.0,
    parameter real PROG_MAX_NS = 30000.0,
    parameter real SK_HALF_NS = 20.0
) (
    // Device pins
    input wire logic select_in,
    input wire logic shift_clock_in,
    input wire logic serial_line_in,
    output logic data_out,
    output logic data_en_out,
    // Protocol faults committed by the host
    output logic [7:0] err_cnt_out
);
    logic [15:0] mem [16];
    logic [15:0] shreg;
    logic [15:0] pend_val;
    logic [7:0] hdr;
    logic [3:0] pend_addr;
    logic prog_en = 1'h0;
    logic started = 1'h0;
    logic pend = 1'h0;
    logic pend_all = 1'h0;
    logic sel_up = 1'h0;
    int cnt = 0;
    int ph = 0;
    real t_sel = -1000.0;
    real t_sk = 0.0;

    initial begin
        err_cnt_out = 8'h00;
        data_out = 1'h0;
        data_en_out = 1'h0;
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // Deselect floats the output and starts a pending program cycle if programming is enabled, else drops it as a fault
    always @(negedge select_in) begin
        data_en_out = 1'h0;
        started = 1'h0;
        // Select settling from unknown at power-up is not a deselect
        if (sel_up) t_sel = $realtime;
        sel_up = 1'h0;
        if (pend && !prog_en) begin
            err_cnt_out++;
            pend = 1'h0;
        end
        foreach (mem[i]) if (pend && (pend_all || i == int'(pend_addr))) mem[i] = pend_val;
    end

    always @(posedge select_in) begin
        if ($realtime - t_sel < SEL_GAP_NS) err_cnt_out++;
        if (pend && ($realtime - t_sel < PROG_MIN_NS || $realtime - t_sel > PROG_MAX_NS))
            err_cnt_out++;
        pend = 1'h0;
        sel_up = 1'h1;
    end

    always @(negedge shift_clock_in) begin
        if (select_in && $realtime - t_sk < SK_HALF_NS) err_cnt_out++;
    end

    always @(posedge shift_clock_in) begin
        t_sk = $realtime;
        if (!select_in) begin
            cnt = 0;
        end else if (!started) begin
            started = serial_line_in;
            cnt = 0;
            ph = 0;
        end else if (ph == 0) begin
            hdr = {hdr[6:0], serial_line_in};
            cnt++;
            if (cnt == 8) begin
                cnt = 0;
                ph = 3;
                pend_all = (hdr[7:6] == 2'h0);
                pend_addr = hdr[3:0];
                pend_val = ERASE_VAL;
                case (hdr[7:6])
                    2'h2: begin
                        ph = 1;
                        shreg = mem[hdr[3:0]];
                        data_en_out = 1'h1;
                        data_out = 1'h0;
                    end
                    2'h1: ph = 2;
                    2'h3: pend = 1'h1;
                    default: case (hdr[5:4])
                        2'h3: prog_en = 1'h1;
                        2'h0: prog_en = 1'h0;
                        2'h2: pend = 1'h1;
                        default: ph = 2;
                    endcase
                endcase
            end
        end else if (ph == 2) begin
            shreg = {shreg[14:0], serial_line_in};
            cnt++;
            if (cnt == 16) begin
                pend = 1'h1;
                pend_val = shreg;
                ph = 3;
            end
        end else if (ph == 1) begin
            if (cnt < 16) begin
                data_out = shreg[15];
                shreg = {shreg[14:0], 1'h0};
                cnt++;
            end else begin
                data_out = serial_line_in;
            end
        end
    end
endmodule // secp_dev_model

// file: secp_host.sv
// Host controller for the serial EEPROM command port
// Functional notes
// - Bits move on rising shift clock edge
// - Instruction starts with select then start bit
// - One instruction per select assertion
// - Start bit, 4-bit opcode, 4-bit address
// - Host releases line after last command bit
// - Select low one clock after read
// - Write: command, 16 data, select low 10ms
// - Program select-low at most 30 ms
// - Shift clock may stop while programming
// - Enable before programming, disable afterwards
// - Shift clock at most 250 kHz
`timescale 1ns/1ps
module secp_host #(
    parameter int PROG_CYC = secp_pkg::PROG_CYC,
    parameter int SCK_HALF_CYC = secp_pkg::SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Command request
    input wire logic cmd_valid_in,
    input wire secp_pkg::secp_cmd_t cmd_op_in,
    input wire logic [secp_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [secp_pkg::DATA_W-1:0] cmd_data_in,
    output logic cmd_ready_out,
    // Command answer
    output logic done_out,
    output logic [secp_pkg::DATA_W-1:0] rd_data_out,
    // Device pins
    output logic select_out,
    output logic shift_clock_out,
    output logic serial_in_out,
    output logic serial_in_oe_n_out,
    input wire logic serial_line_in
);
    secp_pkg::secp_state_t state_ff;
    secp_pkg::secp_step_t step_ff;
    secp_pkg::secp_step_t nxt_step;
    secp_pkg::secp_cmd_t cmd_ff;
    logic [secp_pkg::ADDR_W-1:0] addr_ff;
    logic [secp_pkg::DATA_W-1:0] wdata_ff;
    logic [secp_pkg::FRAME_W-1:0] shreg_ff;
    logic [4:0] bit_cnt_ff;
    logic [4:0] nbits_ff;
    logic [4:0] rd_cnt_ff;
    logic [secp_pkg::DATA_W:0] rd_sh_ff;
    logic [31:0] wait_cnt_ff;
    logic select_ff;
    logic oe_n_ff;
    logic done_ff;
    logic [secp_pkg::DATA_W-1:0] rd_data_ff;
    logic [1:0] din_sync_ff;
    logic sck_run;
    logic sck_rise;
    logic sck_fall;
    logic launch;
    logic shift_end;
    logic read_end;
    logic prog_end;
    logic gap_end;
    logic more_steps;
    logic [3:0] launch_op;
    logic [3:0] launch_addr;

    // Commands that store into the array
    function automatic logic is_prog(input secp_pkg::secp_cmd_t c);
        return (c == secp_pkg::CMD_WRITE) || (c == secp_pkg::CMD_ERASE) ||
               (c == secp_pkg::CMD_ERASE_ALL) || (c == secp_pkg::CMD_WRITE_ALL);
    endfunction

    function automatic logic has_data(input secp_pkg::secp_cmd_t c);
        return (c == secp_pkg::CMD_WRITE) || (c == secp_pkg::CMD_WRITE_ALL);
    endfunction

    function automatic logic [3:0] op_code(input secp_pkg::secp_cmd_t c);
        case (c)
            secp_pkg::CMD_READ: op_code = secp_pkg::OP_READ;
            secp_pkg::CMD_WRITE: op_code = secp_pkg::OP_WRITE;
            secp_pkg::CMD_ERASE: op_code = secp_pkg::OP_ERASE;
            secp_pkg::CMD_PROG_EN: op_code = secp_pkg::OP_PROG_EN;
            secp_pkg::CMD_PROG_DIS: op_code = secp_pkg::OP_PROG_DIS;
            secp_pkg::CMD_ERASE_ALL: op_code = secp_pkg::OP_ERASE_ALL;
            secp_pkg::CMD_WRITE_ALL: op_code = secp_pkg::OP_WRITE_ALL;
            default: op_code = secp_pkg::OP_PROG_DIS;
        endcase
    endfunction

    function automatic logic uses_addr(input secp_pkg::secp_cmd_t c);
        return (c == secp_pkg::CMD_READ) || (c == secp_pkg::CMD_WRITE) ||
               (c == secp_pkg::CMD_ERASE);
    endfunction

    // Pin input crossing
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            din_sync_ff <= 2'b00;
        end else begin
            din_sync_ff <= {din_sync_ff[0], serial_line_in};
        end
    end

    secp_sck_gen #(
        .HALF_CYC(SCK_HALF_CYC)
    ) u_sck (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .run_in(sck_run),
        .sck_out(shift_clock_out),
        .rise_out(sck_rise),
        .fall_out(sck_fall)
    );

    // Clock runs only inside a frame; stopped while programming
    assign sck_run = (state_ff == secp_pkg::ST_SHIFT) || (state_ff == secp_pkg::ST_READ);

    assign more_steps = (step_ff == secp_pkg::STEP_PRE) ||
                        ((step_ff == secp_pkg::STEP_MAIN) && is_prog(cmd_ff));
    assign shift_end = (state_ff == secp_pkg::ST_SHIFT) && sck_fall && (bit_cnt_ff == nbits_ff);
    assign read_end = (state_ff == secp_pkg::ST_READ) && sck_fall &&
                      (rd_cnt_ff == secp_pkg::RD_BITS);
    assign prog_end = (state_ff == secp_pkg::ST_PROG) && (wait_cnt_ff == 32'(PROG_CYC - 1));
    assign gap_end = (state_ff == secp_pkg::ST_GAP) &&
                     (wait_cnt_ff == 32'(secp_pkg::SEL_GAP_CYC - 1));
    assign launch = ((state_ff == secp_pkg::ST_IDLE) && cmd_valid_in) || (gap_end && more_steps);
    assign cmd_ready_out = (state_ff == secp_pkg::ST_IDLE);

    // Programming is wrapped in enable and disable instructions
    always_comb begin
        nxt_step = step_ff;
        if (state_ff == secp_pkg::ST_IDLE) begin
            nxt_step = is_prog(cmd_op_in) ? secp_pkg::STEP_PRE : secp_pkg::STEP_MAIN;
        end else if (step_ff == secp_pkg::STEP_PRE) begin
            nxt_step = secp_pkg::STEP_MAIN;
        end else begin
            nxt_step = secp_pkg::STEP_POST;
        end
    end

    always_comb begin
        launch_op = secp_pkg::OP_PROG_DIS;
        launch_addr = secp_pkg::ADDR_NONE;
        case (nxt_step)
            secp_pkg::STEP_PRE: launch_op = secp_pkg::OP_PROG_EN;
            secp_pkg::STEP_POST: launch_op = secp_pkg::OP_PROG_DIS;
            secp_pkg::STEP_MAIN: begin
                if (state_ff == secp_pkg::ST_IDLE) begin
                    launch_op = op_code(cmd_op_in);
                    launch_addr = uses_addr(cmd_op_in) ? cmd_addr_in : secp_pkg::ADDR_NONE;
                end else begin
                    launch_op = op_code(cmd_ff);
                    launch_addr = uses_addr(cmd_ff) ? addr_ff : secp_pkg::ADDR_NONE;
                end
            end
            default: launch_op = secp_pkg::OP_PROG_DIS;
        endcase
    end

    // Request capture
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_ff <= secp_pkg::CMD_READ;
            addr_ff <= 4'h0;
            wdata_ff <= 16'h0000;
        end else if ((state_ff == secp_pkg::ST_IDLE) && cmd_valid_in) begin
            cmd_ff <= cmd_op_in;
            addr_ff <= cmd_addr_in;
            wdata_ff <= cmd_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            step_ff <= secp_pkg::STEP_MAIN;
        end else if (launch) begin
            step_ff <= nxt_step;
        end
    end

    // Sequencer
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= secp_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                secp_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_ff <= secp_pkg::ST_SHIFT;
                    end
                end
                secp_pkg::ST_SHIFT: begin
                    if (shift_end) begin
                        if ((step_ff == secp_pkg::STEP_MAIN) && (cmd_ff == secp_pkg::CMD_READ)) begin
                            state_ff <= secp_pkg::ST_READ;
                        end else if ((step_ff == secp_pkg::STEP_MAIN) && is_prog(cmd_ff)) begin
                            state_ff <= secp_pkg::ST_PROG;
                        end else begin
                            state_ff <= secp_pkg::ST_GAP;
                        end
                    end
                end
                secp_pkg::ST_READ: begin
                    if (read_end) begin
                        state_ff <= secp_pkg::ST_GAP;
                    end
                end
                secp_pkg::ST_PROG: begin
                    if (prog_end) begin
                        state_ff <= secp_pkg::ST_GAP;
                    end
                end
                secp_pkg::ST_GAP: begin
                    if (launch) begin
                        state_ff <= secp_pkg::ST_SHIFT;
                    end else if (gap_end) begin
                        state_ff <= secp_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= secp_pkg::ST_IDLE;
            endcase
        end
    end

    // Select: one assertion per instruction, low while programming and between frames
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            select_ff <= 1'b0;
        end else if (launch) begin
            select_ff <= 1'b1;
        end else if (shift_end && !((step_ff == secp_pkg::STEP_MAIN) &&
                                    (cmd_ff == secp_pkg::CMD_READ))) begin
            select_ff <= 1'b0;
        end else if (read_end) begin
            select_ff <= 1'b0;
        end
    end

    // Wait counter for program hold and deselect gap
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_cnt_ff <= 32'h0000_0000;
        end else if ((state_ff == secp_pkg::ST_PROG) || (state_ff == secp_pkg::ST_GAP)) begin
            if (prog_end || gap_end) begin
                wait_cnt_ff <= 32'h0000_0000;
            end else begin
                wait_cnt_ff <= wait_cnt_ff + 32'h0000_0001;
            end
        end else begin
            wait_cnt_ff <= 32'h0000_0000;
        end
    end

    // Outgoing frame: start bit, opcode, address, optional data, MSB first
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shreg_ff <= 25'h0000000;
            nbits_ff <= 5'h00;
            bit_cnt_ff <= 5'h00;
        end else if (launch) begin
            shreg_ff <= {secp_pkg::START_BIT, launch_op, launch_addr,
                         (state_ff == secp_pkg::ST_IDLE) ? cmd_data_in : wdata_ff};
            nbits_ff <= ((nxt_step == secp_pkg::STEP_MAIN) &&
                         has_data((state_ff == secp_pkg::ST_IDLE) ? cmd_op_in : cmd_ff)) ?
                        secp_pkg::WR_BITS : secp_pkg::HDR_BITS;
            bit_cnt_ff <= 5'h00;
        end else if (state_ff == secp_pkg::ST_SHIFT) begin
            if (sck_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
            if (sck_fall) begin
                shreg_ff <= {shreg_ff[secp_pkg::FRAME_W-2:0], 1'b0};
            end
        end
    end

    // Line drive: only through the command bits, released for device output
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe_n_ff <= 1'b1;
        end else if (launch) begin
            oe_n_ff <= 1'b0;
        end else if (shift_end) begin
            oe_n_ff <= 1'b1;
        end
    end

    assign select_out = select_ff;
    assign serial_in_out = (state_ff == secp_pkg::ST_SHIFT) ? shreg_ff[secp_pkg::FRAME_W-1] : 1'b0;
    assign serial_in_oe_n_out = oe_n_ff;

    // Read capture: dummy bit then 16 data bits
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_cnt_ff <= 5'h00;
            rd_sh_ff <= 17'h00000;
        end else if (state_ff != secp_pkg::ST_READ) begin
            rd_cnt_ff <= 5'h00;
        end else if (sck_rise) begin
            rd_cnt_ff <= rd_cnt_ff + 5'h01;
            rd_sh_ff <= {rd_sh_ff[secp_pkg::DATA_W-1:0], din_sync_ff[1]};
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_ff <= 16'h0000;
        end else if (read_end) begin
            rd_data_ff <= rd_sh_ff[secp_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= gap_end && !more_steps;
        end
    end

    assign done_out = done_ff;
    assign rd_data_out = rd_data_ff;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    chk_stable_at_rise: assert property ($rose(shift_clock_out) |-> $stable(serial_in_out))
        else $error("serial data changed at shift clock rise");
    chk_start_bit_first: assert property ($rose(select_out) |->
        serial_in_out && !serial_in_oe_n_out && !shift_clock_out)
        else $error("select rose without start bit driven");
    chk_one_instr: assert property ($rose(select_out) |-> bit_cnt_ff == 5'h00)
        else $error("select rose with bits pending");
    chk_frame_len: assert property (shift_end |->
        (nbits_ff == secp_pkg::HDR_BITS) || (nbits_ff == secp_pkg::WR_BITS))
        else $error("frame length wrong");
    chk_release_read: assert property (state_ff == secp_pkg::ST_READ |-> serial_in_oe_n_out)
        else $error("host drives line during read");
    chk_gap_length: assert property ($rose(select_out) && $past(state_ff) == secp_pkg::ST_GAP |->
        $past(wait_cnt_ff) == 32'(secp_pkg::SEL_GAP_CYC - 1))
        else $error("deselect gap too short");
    chk_prog_hold: assert property (state_ff == secp_pkg::ST_PROG && $fell(select_out) |->
        !select_out throughout (state_ff == secp_pkg::ST_PROG)[*8])
        else $error("select rose during program hold");
    chk_prog_max: assert property (state_ff == secp_pkg::ST_PROG |->
        wait_cnt_ff < 32'(secp_pkg::PROG_MAX_CYC))
        else $error("program hold exceeds maximum");
    chk_clk_parked: assert property (state_ff == secp_pkg::ST_PROG |-> !shift_clock_out)
        else $error("shift clock running while programming");
    chk_enable_first: assert property (launch && nxt_step == secp_pkg::STEP_MAIN &&
        state_ff != secp_pkg::ST_IDLE |-> step_ff == secp_pkg::STEP_PRE)
        else $error("program command without prior enable");

    cov_read: cover property (read_end);
    cov_write: cover property (prog_end && cmd_ff == secp_pkg::CMD_WRITE);
    cov_erase_all: cover property (prog_end && cmd_ff == secp_pkg::CMD_ERASE_ALL);
    cov_back_to_back: cover property (done_out ##1 cmd_valid_in && cmd_ready_out);
endmodule // secp_host

// file: secp_host_tb.sv
// Self-checking bench for the serial EEPROM host controller
`timescale 1ns/1ps
module secp_host_tb;
    localparam int HALF = 4;
    localparam int PROG = 2000;
    localparam logic [15:0] ERASED = 16'hFFFF;
    typedef struct packed {
        secp_pkg::secp_cmd_t op;
        logic [3:0] addr;
        logic [15:0] data;
        logic [15:0] exp;
    } secp_row_t;

    logic clock_in = 1'h0;
    logic nrst_in = 1'h0;
    logic cmd_valid_in = 1'h0;
    secp_pkg::secp_cmd_t cmd_op_in = secp_pkg::CMD_READ;
    logic [3:0] cmd_addr_in = 4'h0;
    logic [15:0] cmd_data_in = 16'h0000;
    logic cmd_ready_out, done_out, select_out, shift_clock_out, serial_in_out, serial_in_oe_n_out;
    logic [15:0] rd_data_out;
    logic dev_do, dev_en;
    logic [7:0] err_cnt;
    logic float_ff = 1'h0;
    wire logic line = !serial_in_oe_n_out ? serial_in_out : dev_en ? dev_do : float_ff;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    secp_row_t rows [15] = '{
        '{secp_pkg::CMD_WRITE, 4'h3, 16'hA5C3, 16'h0000},
        '{secp_pkg::CMD_READ, 4'h3, 16'h0000, 16'hA5C3},
        '{secp_pkg::CMD_WRITE, 4'hF, 16'h1234, 16'h0000},
        '{secp_pkg::CMD_READ, 4'hF, 16'h0000, 16'h1234},
        '{secp_pkg::CMD_READ, 4'h3, 16'h0000, 16'hA5C3},
        '{secp_pkg::CMD_ERASE, 4'h3, 16'h0000, 16'h0000},
        '{secp_pkg::CMD_READ, 4'h3, 16'h0000, ERASED},
        '{secp_pkg::CMD_WRITE_ALL, 4'h0, 16'h0F0F, 16'h0000},
        '{secp_pkg::CMD_READ, 4'h9, 16'h0000, 16'h0F0F},
        '{secp_pkg::CMD_ERASE_ALL, 4'h0, 16'h0000, 16'h0000},
        '{secp_pkg::CMD_READ, 4'h0, 16'h0000, ERASED},
        '{secp_pkg::CMD_PROG_EN, 4'h0, 16'h0000, 16'h0000},
        '{secp_pkg::CMD_PROG_DIS, 4'h0, 16'h0000, 16'h0000},
        '{secp_pkg::CMD_WRITE, 4'h0, 16'h8001, 16'h0000},
        '{secp_pkg::CMD_READ, 4'h0, 16'h0000, 16'h8001}
    };

    secp_host #(.PROG_CYC(PROG), .SCK_HALF_CYC(HALF)) dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .cmd_ready_out(cmd_ready_out), .done_out(done_out), .rd_data_out(rd_data_out),
        .select_out(select_out), .shift_clock_out(shift_clock_out),
        .serial_in_out(serial_in_out), .serial_in_oe_n_out(serial_in_oe_n_out),
        .serial_line_in(line)
    );

    secp_dev_model #(.ERASE_VAL(ERASED), .SEL_GAP_NS(2 * HALF * 5.0), .PROG_MIN_NS(PROG * 5.0),
        .PROG_MAX_NS(PROG * 15.0), .SK_HALF_NS(HALF * 5.0)) model (
        .select_in(select_out), .shift_clock_in(shift_clock_out), .serial_line_in(line),
        .data_out(dev_do), .data_en_out(dev_en), .err_cnt_out(err_cnt)
    );

    always #2.5 clock_in = ~clock_in;

    // Released line shows a changing level, never a stale one
    always @(posedge clock_in) begin
        float_ff <= ~float_ff;
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("Timeout after %0d cycles", cyc);
            conclude();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic run_cmd(input secp_pkg::secp_cmd_t op, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        cmd_valid_in <= 1'h1;
        cmd_op_in <= op;
        cmd_addr_in <= a;
        cmd_data_in <= d;
        @(posedge clock_in);
        cmd_valid_in <= 1'h0;
        #1 check("ready after take", {15'h0000, cmd_ready_out}, 16'h0000);
        while (done_out !== 1'h1 && n < 6000) begin
            @(posedge clock_in);
            #1 n++;
        end
        check("done seen", {15'h0000, done_out}, 16'h0001);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Pins: select, clock, serial in, oe_n, ready, done
    function automatic logic [15:0] pins();
        return {10'h000, select_out, shift_clock_out, serial_in_out, serial_in_oe_n_out,
            cmd_ready_out, done_out};
    endfunction

    initial begin
        repeat (2) @(posedge clock_in);
        #1 check("reset pins", pins(), 16'h0006);
        check("reset read data", rd_data_out, 16'h0000);
        @(posedge clock_in);
        nrst_in <= 1'h1;
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].addr, rows[i].data);
            if (rows[i].op == secp_pkg::CMD_READ)
                check("read data", rd_data_out, rows[i].exp);
            $display("test %0d done", i);
        end
        // Reset while read data shifts and the shift clock is low
        @(posedge clock_in);
        cmd_valid_in <= 1'h1;
        cmd_addr_in <= 4'h0;
        cmd_op_in <= secp_pkg::CMD_READ;
        @(posedge clock_in);
        cmd_valid_in <= 1'h0;
        repeat (98) @(posedge clock_in);
        nrst_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        #1 check("mid reset pins", pins(), 16'h0006);
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'h1;
        run_cmd(secp_pkg::CMD_READ, 4'h0, 16'h0000);
        check("read after reset", rd_data_out, 16'h8001);
        $display("test reset done");
        check("device faults", {8'h00, err_cnt}, 16'h0000);
        conclude();
    end
endmodule // secp_host_tb

// file: secp_pkg.sv
// Constants and types shared by the serial EEPROM command port host
package secp_pkg;
    // Clock and shift-clock timing
    localparam int CLK_HZ = 200_000_000;
    localparam int SCK_MAX_HZ = 250_000;
    localparam int SCK_HALF_CYC = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
    localparam int SEL_GAP_CYC = 2 * SCK_HALF_CYC;
    // Program timing, held select low
    localparam int PROG_TIME_US = 10_000;
    localparam int PROG_MAX_US = 30_000;
    localparam int PROG_CYC = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int PROG_MAX_CYC = PROG_MAX_US * (CLK_HZ / 1_000_000);
    // Frame layout
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int FRAME_W = 1 + 4 + ADDR_W + DATA_W;
    localparam logic [4:0] HDR_BITS = 5'h09;
    localparam logic [4:0] WR_BITS = 5'h19;
    localparam logic [4:0] RD_BITS = 5'h11;
    localparam logic START_BIT = 1'b1;
    // Opcode field values
    localparam logic [3:0] OP_READ = 4'h8;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_ERASE = 4'hC;
    localparam logic [3:0] OP_PROG_EN = 4'h3;
    localparam logic [3:0] OP_PROG_DIS = 4'h0;
    localparam logic [3:0] OP_ERASE_ALL = 4'h2;
    localparam logic [3:0] OP_WRITE_ALL = 4'h1;
    localparam logic [3:0] ADDR_NONE = 4'h0;

    typedef enum logic [2:0] {
        CMD_READ = 3'b000,
        CMD_WRITE = 3'b001,
        CMD_ERASE = 3'b010,
        CMD_PROG_EN = 3'b011,
        CMD_PROG_DIS = 3'b100,
        CMD_ERASE_ALL = 3'b101,
        CMD_WRITE_ALL = 3'b110
    } secp_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SHIFT = 3'b001,
        ST_READ = 3'b010,
        ST_PROG = 3'b011,
        ST_GAP = 3'b100
    } secp_state_t;

    typedef enum logic [1:0] {
        STEP_PRE = 2'b00,
        STEP_MAIN = 2'b01,
        STEP_POST = 2'b10
    } secp_step_t;
endpackage

// file: secp_sck_gen.sv
// Shift clock divider with edge strobes
`timescale 1ns/1ps
module secp_sck_gen #(
    parameter int HALF_CYC = secp_pkg::SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Control
    input wire logic run_in,
    // Shift clock and strobes
    output logic sck_out,
    output logic rise_out,
    output logic fall_out
);
    logic [15:0] cnt_ff;
    logic sck_ff;
    logic wrap;

    assign wrap = run_in && (cnt_ff == 16'(HALF_CYC - 1));
    assign rise_out = wrap && !sck_ff;
    assign fall_out = wrap && sck_ff;
    assign sck_out = sck_ff;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff <= 16'h0000;
        end else if (!run_in || wrap) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    // Clock parks low whenever stopped
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_ff <= 1'b0;
        end else if (!run_in) begin
            sck_ff <= 1'b0;
        end else if (wrap) begin
            sck_ff <= !sck_ff;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    chk_half_period: assert property ($changed(sck_ff) && run_in |-> $past(wrap))
        else $error("shift clock toggled before half period");
endmodule // secp_sck_gen
